// [shared/fcel_pkg.sv]
package fcel_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [11:0] IDX_CLEAR_CMD   = 12'h5D3; // fault_clear_command
    localparam logic [11:0] IDX_HIST_CAP    = 12'h5D6; // history_capacity
    localparam logic [11:0] IDX_HIST_WPOS   = 12'h5D7; // history_write_position
    localparam logic [11:0] IDX_HIST_RIDX   = 12'h5DA; // history_read_index
    localparam logic [11:0] IDX_HIST_TIME   = 12'h5DB; // history_entry_time
    localparam logic [11:0] IDX_HIST_WORD_A = 12'h5DC; // history_entry_word_a
    localparam logic [11:0] IDX_HIST_WORD_B = 12'h5DD; // history_entry_word_b
    localparam logic [11:0] IDX_CTRL_FLAGS  = 12'h5F2; // controller_state_flags
    localparam logic [11:0] IDX_HIST_STEPS  = 12'h668; // history_step_count
    localparam logic [11:0] IDX_IRQ_STATUS  = 12'h700; // sticky event bits
    localparam logic [11:0] IDX_IRQ_MASK    = 12'h701; // event enables

    // controller_state_flags bit positions
    localparam int FLAG_CLEAR_BUSY = 0; // clear sequence running
    localparam int FLAG_MON_ON     = 1; // real-time monitoring active
    localparam int FLAG_ANY_FAULT  = 2; // some clearable fault latched
    localparam int FLAG_NONCLEAR   = 6; // non-clearable fault has occurred

    // interrupt event bit positions
    localparam int EV_FAULT   = 0; // new clearable fault latched
    localparam int EV_DONE    = 1; // clear sequence finished
    localparam int EV_NONCLR  = 2; // non-clearable fault latched
    localparam int EV_W       = 3;

    // values
    localparam logic [15:0] CMD_START      = 16'h0001; // command value that starts a clear
    localparam logic [15:0] CMD_IDLE       = 16'h0000; // reads when no clear runs
    localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;
    localparam logic [EV_W-1:0] MASK_RESET = 3'h0;

    // timing: timestamp runs in seconds
    localparam int  CLK_HZ       = 100_000_000;
    localparam int  STAMP_PERIOD_S = 1;
    localparam int  STAMP_CYCLES = CLK_HZ * STAMP_PERIOD_S;

    // history depth
    localparam int  HIST_DEPTH   = 850;

    // clear sequence states
    typedef enum logic [2:0] {
        CLR_IDLE    = 3'b000,
        CLR_SUSPEND = 3'b001,
        CLR_WIPE    = 3'b010,
        CLR_REQUEST = 3'b011,
        CLR_WAIT_NF = 3'b100,
        CLR_RESUME  = 3'b101
    } fcel_clr_e;

    // one history entry
    typedef struct packed {
        logic [31:0] stamp; // seconds since reset
        logic [31:0] code;  // fault number that was latched
        logic [31:0] snap;  // controller flags and counter at that time
    } fcel_hist_s;

endpackage

// [verif/fcel_sva.sv]
`timescale 1ns/1ps
module fcel_sva #(
    parameter int NF = 16, // clearable fault inputs
    parameter int NX = 8   // non-clearable fault inputs
) (
    input wire logic          clk,            // system clock
    input wire logic          rst_n,          // sync reset, active low
    input wire logic [13:0]   address,        // bus byte address
    input wire logic          read,           // bus read strobe
    input wire logic          write,          // bus write strobe
    input wire logic [3:0]    byteenable,     // bus byte lanes
    input wire logic [31:0]   writedata,      // bus write data
    input wire logic [31:0]   readdata,       // bus read data
    input wire logic          waitrequest,    // bus stall
    input wire logic [NF-1:0] fault_pin,      // clearable fault pins
    input wire logic [NX-1:0] nonclear_fault, // non-clearable events
    input wire logic          drive_nonfault, // drive in non-fault state
    input wire logic          nonfault_req,   // request to drive
    input wire logic [NF-1:0] fault_latched,  // latched faults
    input wire logic          monitor_on,     // monitoring active
    input wire logic          irq             // level interrupt
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // one wait state, then exactly one answer cycle
    property p_bus_ans; (read || write) && waitrequest |=> !waitrequest; endproperty
    property p_bus_one; !waitrequest |=> waitrequest; endproperty
    // the drive is only asked while monitoring is off
    property p_susp; nonfault_req |-> !monitor_on; endproperty
    // nothing new is latched once monitoring has stopped
    property p_nolatch; !monitor_on && $past(!monitor_on) |-> (fault_latched & ~$past(fault_latched)) == '0;
    endproperty
    // records are wiped shortly after suspension
    property p_wipe; $fell(monitor_on) |-> ##[1:4] (fault_latched == '0); endproperty
    // request follows the wipe within a bound
    property p_req; $fell(monitor_on) |-> ##[1:4] nonfault_req; endproperty
    // request stands until the drive answers
    property p_hold; nonfault_req && !drive_nonfault |=> nonfault_req; endproperty
    property p_drop; nonfault_req && drive_nonfault |=> !nonfault_req; endproperty
    // monitoring comes back right after the request ends
    property p_resume; $fell(nonfault_req) |-> ##[1:3] monitor_on; endproperty
    a_bus_ans: assert property (p_bus_ans) else $error("no answer after one wait state");
    a_bus_one: assert property (p_bus_one) else $error("answer longer than one cycle");
    a_susp: assert property (p_susp) else $error("request while monitoring on");
    a_nolatch: assert property (p_nolatch) else $error("latch while suspended");
    a_wipe: assert property (p_wipe) else $error("latches not wiped");
    a_req: assert property (p_req) else $error("no non-fault request");
    a_hold: assert property (p_hold) else $error("request dropped early");
    a_drop: assert property (p_drop) else $error("request kept after answer");
    a_resume: assert property (p_resume) else $error("monitoring not resumed");
    c_clear: cover property ($fell(nonfault_req));
    c_latch: cover property ($rose(|fault_latched));
    c_irq: cover property ($rose(irq));
endmodule

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
    import fcel_pkg::*;
    logic clk = 0, rst_n = 0, read = 0, write = 0, drive_nonfault = 0, waitrequest, nonfault_req, monitor_on, irq;
    logic [13:0] address = '0;            // bus address
    logic [3:0]  byteenable = 4'hF;       // all lanes
    logic [31:0] writedata = '0, readdata, rd; // bus data
    logic [15:0] fault_pin = '0, fault_latched; // clearable faults
    logic [7:0]  nonclear_fault = '0;     // non-clearable events
    int errors = 0, total_checks = 0;
    // short depth and stamp keep the run brief
    fcel_top #(.DEPTH(8), .STAMP_CYCLES(10)) DUT (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .fault_pin(fault_pin), .nonclear_fault(nonclear_fault),
        .drive_nonfault(drive_nonfault), .nonfault_req(nonfault_req), .fault_latched(fault_latched),
        .monitor_on(monitor_on), .irq(irq));
    always #5 clk = ~clk;
    task end_sim;
        if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one bus cycle held until waitrequest is sampled low
    task bus(input logic w, input logic [11:0] idx, input logic [31:0] wd, output logic [31:0] d);
        int n;
        @(posedge clk);
        address <= {idx, 2'b00};
        writedata <= wd;
        read <= !w;
        write <= w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        d = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 50) begin
            errors++;
            end_sim();
        end
    endtask
    task rdchk(input string nm, input logic [11:0] idx, input logic [31:0] e);
        bus(0, idx, 0, rd);
        chk(nm, e, rd);
    endtask
    task wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // full clear with a slow drive answer and a stray write mid-run
    task do_clear;
        int n;
        drive_nonfault <= 1'b0;
        bus(1, IDX_CLEAR_CMD, 32'h0000_0001, rd);
        rdchk("cmd_busy", IDX_CLEAR_CMD, 32'h0000_0001);
        bus(1, IDX_CLEAR_CMD, 32'h0000_0000, rd);
        rdchk("cmd_no_abort", IDX_CLEAR_CMD, 32'h0000_0001);
        n = 0;
        while (nonfault_req !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        chk("req_up", 1, nonfault_req);
        if (nonfault_req !== 1'b1) begin
            end_sim();
        end
        chk("mon_off", 0, monitor_on);
        chk("wiped", 0, fault_latched);
        drive_nonfault <= 1'b1;
        n = 0;
        do begin
            bus(0, IDX_CLEAR_CMD, 0, rd);
            n++;
        end while (rd !== 32'h0 && n < 20);
        chk("cmd_done", 0, rd);
        if (rd !== 32'h0) begin
            end_sim();
        end
        wait_cyc(3);
        chk("mon_back", 1, monitor_on);
    endtask
    task t_regs;
        rdchk("capacity", IDX_HIST_CAP, 32'h0000_0008);
        rdchk("cmd_idle", IDX_CLEAR_CMD, 32'h0000_0000);
        rdchk("flags", IDX_CTRL_FLAGS, 32'h0000_0002);
        rdchk("unmapped", 12'h123, UNMAPPED_DATA);
    endtask
    // a fault still present re-latches once monitoring returns
    task t_clear;
        fault_pin <= 16'h0008;
        wait_cyc(10);
        chk("latched", 16'h0008, fault_latched);
        do_clear();
        wait_cyc(10); // host lets re-detection settle, scaled down for the bench
        chk("relatched", 16'h0008, fault_latched);
        fault_pin <= 16'h0000;
    endtask
    task t_nonclear;
        nonclear_fault <= 8'h01;
        @(posedge clk);
        nonclear_fault <= 8'h00;
        wait_cyc(3);
        bus(0, IDX_CTRL_FLAGS, 0, rd);
        chk("nonclr_bit", 1, rd[FLAG_NONCLEAR]);
        do_clear();
        bus(0, IDX_CTRL_FLAGS, 0, rd);
        chk("nonclr_kept", 1, rd[FLAG_NONCLEAR]);
    endtask
    task t_irq;
        chk("irq_masked", 0, irq);
        bus(1, IDX_IRQ_MASK, 32'h0000_0002, rd);
        wait_cyc(3);
        chk("irq_done", 1, irq);
        bus(1, IDX_IRQ_STATUS, 32'h0000_0007, rd);
        wait_cyc(3);
        chk("irq_cleared", 0, irq);
        rdchk("status", IDX_IRQ_STATUS, 32'h0000_0000);
    endtask
    // more faults than entries so the write position wraps; eleven entries in all:
    // two from t_clear (code 3 twice), then codes 0 to 8, so slot 0 now holds code 6
    task t_hist;
        for (int i = 0; i < 9; i++) begin
            fault_pin <= 16'h0001 << i;
            wait_cyc(10);
            fault_pin <= 16'h0000;
            do_clear();
        end
        rdchk("steps", IDX_HIST_STEPS, 32'h0000_000B);
        rdchk("wpos", IDX_HIST_WPOS, 32'h0000_0003);
        bus(1, IDX_HIST_RIDX, 32'h0000_0000, rd);
        rdchk("oldest_overwritten", IDX_HIST_WORD_A, 32'h0000_0006);
        bus(1, IDX_HIST_RIDX, 32'h0000_0003, rd);
        rdchk("ridx", IDX_HIST_RIDX, 32'h0000_0003);
        rdchk("oldest_kept", IDX_HIST_WORD_A, 32'h0000_0001);
    endtask
    initial begin
        wait_cyc(6);
        rst_n <= 1'b1;
        t_regs();
        t_clear();
        t_nonclear();
        t_irq();
        t_hist();
        end_sim();
    end
endmodule
bind fcel_top fcel_sva #(.NF(NF), .NX(NX)) u_sva (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .fault_pin(fault_pin), .nonclear_fault(nonclear_fault),
    .drive_nonfault(drive_nonfault), .nonfault_req(nonfault_req), .fault_latched(fault_latched),
    .monitor_on(monitor_on), .irq(irq));

// [verilog/fcel_top.sv]
`timescale 1ns/1ps

// Operation
// - all faults clear except init and exception ones
// - flag bit 6 shows non-clearable fault occurred
// - first suspend real-time fault monitoring
// - then wipe latches, the any-fault flag and the fault counter
// - then request non-fault state from drive
// - command returns zero once non-fault reported
// - then monitoring resumes and re-latches faults
// - circular fault history, newest overwrites oldest
module fcel_top #(
    parameter int NF           = 16,                      // clearable fault inputs
    parameter int NX           = 8,                       // non-clearable fault inputs
    parameter int DEPTH        = fcel_pkg::HIST_DEPTH,    // history entries
    parameter int STAMP_CYCLES = fcel_pkg::STAMP_CYCLES   // cycles per timestamp second
) (
    input  wire logic          clk,              // 100 MHz system clock
    input  wire logic          rst_n,            // synchronous reset, active low
    input  wire logic [13:0]   address,          // avalon byte address
    input  wire logic          read,             // avalon read strobe
    input  wire logic          write,            // avalon write strobe
    input  wire logic [3:0]    byteenable,       // avalon byte lanes
    input  wire logic [31:0]   writedata,        // avalon write data
    output logic      [31:0]   readdata,         // avalon read data
    output logic               waitrequest,      // avalon stall
    input  wire logic [NF-1:0] fault_pin,        // async fault conditions from pins
    input  wire logic [NX-1:0] nonclear_fault,   // init and exception faults, same clock
    input  wire logic          drive_nonfault,   // drive state machine is in non-fault state
    output logic               nonfault_req,     // request to drive state machine
    output logic [NF-1:0]      fault_latched,    // latched clearable faults
    output logic               monitor_on,       // real-time monitoring active
    output logic               irq               // level interrupt
);
    import fcel_pkg::*;

    localparam int AW = $clog2(DEPTH);

    // lowest set bit of a fault vector, as a 32-bit code
    function automatic logic [31:0] first_set(input logic [NF-1:0] v);
        logic [31:0] r;
        r = 32'h0000_0000;
        for (int i = NF - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 32'(i);
            end
        end
        return r;
    endfunction

    // next ring slot, wrapping at the depth
    function automatic logic [AW-1:0] ring_next(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    // pin synchroniser: three stages, change counted when second and third agree
    logic [NF-1:0] sync1_reg;       // first stage, read only by second
    logic [NF-1:0] sync2_reg;       // second stage
    logic [NF-1:0] sync3_reg;       // third stage
    logic [NF-1:0] fault_cond_reg;  // filtered condition
    wire  [NF-1:0] agree = ~(sync2_reg ^ sync3_reg); // stages agree

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_reg      <= '0;
            sync2_reg      <= '0;
            sync3_reg      <= '0;
            fault_cond_reg <= '0;
        end else begin
            sync1_reg      <= fault_pin;
            sync2_reg      <= sync1_reg;
            sync3_reg      <= sync2_reg;
            fault_cond_reg <= (agree & sync3_reg) | (~agree & fault_cond_reg);
        end
    end

    // state
    fcel_clr_e     clr_reg;          // clear sequence state
    logic          mon_reg;          // monitoring enabled
    logic          req_reg;          // non-fault request to drive
    logic [NF-1:0] latch_reg;        // latched clearable faults
    logic [31:0]   fcount_reg;       // fault counter, counts latch events
    logic [NX-1:0] nclatch_reg;      // non-clearable faults, never wiped
    logic [EV_W-1:0] sts_reg;        // sticky interrupt status
    logic [EV_W-1:0] mask_reg;       // interrupt mask
    logic [AW-1:0] wpos_reg;         // next slot to write
    logic [15:0]   ridx_reg;         // software read pointer
    logic [31:0]   steps_reg;        // entries logged since reset
    logic [31:0]   stamp_reg;        // seconds counter
    logic [31:0]   tick_reg;         // divider for the seconds counter
    logic [31:0]   rdata_reg;        // bus read data
    logic          wait_reg;         // bus stall
    logic          irq_reg;          // interrupt output

    // history ring; holds value across clears, lost only with the array itself
    fcel_hist_s    hist_mem [DEPTH];

    // bus decode
    wire        req     = read | write;                  // a request stands
    wire        accept  = req & ~wait_reg;                // edge where master sees waitrequest low
    wire [11:0] idx     = address[13:2];                  // register index
    wire        wr_ok   = accept & write;                 // write takes effect now
    wire        wr_lo   = wr_ok & byteenable[0];          // low byte lane written
    wire        wr_cmd  = wr_lo & (idx == IDX_CLEAR_CMD);
    wire        wr_ridx = wr_ok & (idx == IDX_HIST_RIDX);
    wire        wr_sts  = wr_lo & (idx == IDX_IRQ_STATUS);
    wire        wr_mask = wr_lo & (idx == IDX_IRQ_MASK);

    // start only from idle with the start value; busy writes fall through
    wire        start   = wr_cmd & (clr_reg == CLR_IDLE) & (writedata[15:0] == CMD_START);
    wire        busy    = (clr_reg != CLR_IDLE);

    // clearable fault detection only while monitoring is on; non-clearable faults are always detected
    wire [NF-1:0] new_fault = mon_reg ? (fault_cond_reg & ~latch_reg) : '0;
    wire          any_new   = |new_fault;
    wire [NX-1:0] new_nc    = nonclear_fault & ~nclatch_reg;
    wire          wipe      = (clr_reg == CLR_WIPE);

    // controller flags byte
    wire [7:0] flags;
    assign flags[FLAG_CLEAR_BUSY] = busy;
    assign flags[FLAG_MON_ON]     = mon_reg;
    assign flags[FLAG_ANY_FAULT]  = |latch_reg;
    assign flags[5:3]             = 3'h0;
    assign flags[FLAG_NONCLEAR]   = |nclatch_reg;
    assign flags[7]               = 1'b0;

    // history read port
    wire [AW-1:0] rsel    = (ridx_reg < 16'(DEPTH)) ? ridx_reg[AW-1:0] : '0;
    fcel_hist_s   rentry;
    assign rentry = hist_mem[rsel];

    // events for the interrupt block
    wire [EV_W-1:0] ev;
    assign ev[EV_FAULT]  = any_new;
    assign ev[EV_DONE]   = (clr_reg == CLR_RESUME);
    assign ev[EV_NONCLR] = |new_nc;

    // read mux
    wire [31:0] rd_mux =
        (idx == IDX_CLEAR_CMD)   ? {16'h0000, busy ? CMD_START : CMD_IDLE} :
        (idx == IDX_HIST_CAP)    ? 32'(DEPTH) :
        (idx == IDX_HIST_WPOS)   ? {16'h0000, 16'(wpos_reg)} :
        (idx == IDX_HIST_RIDX)   ? {16'h0000, ridx_reg} :
        (idx == IDX_HIST_TIME)   ? rentry.stamp :
        (idx == IDX_HIST_WORD_A) ? rentry.code :
        (idx == IDX_HIST_WORD_B) ? rentry.snap :
        (idx == IDX_CTRL_FLAGS)  ? {24'h000000, flags} :
        (idx == IDX_HIST_STEPS)  ? steps_reg :
        (idx == IDX_IRQ_STATUS)  ? {29'h0, sts_reg} :
        (idx == IDX_IRQ_MASK)    ? {29'h0, mask_reg} :
                                   UNMAPPED_DATA;

    // bus slave: one stall cycle, then a one-cycle answer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wait_reg  <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end else if (req && wait_reg) begin
            wait_reg  <= 1'b0;
            rdata_reg <= read ? rd_mux : 32'h0000_0000;
        end else begin
            wait_reg  <= 1'b1;
        end
    end

    // clear sequence: suspend, wipe, request, wait, resume
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clr_reg <= CLR_IDLE;
            mon_reg <= 1'b1;
            req_reg <= 1'b0;
        end else begin
            unique case (clr_reg)
                CLR_IDLE: begin
                    if (start) begin
                        clr_reg <= CLR_SUSPEND;
                    end
                end
                CLR_SUSPEND: begin
                    mon_reg <= 1'b0;
                    clr_reg <= CLR_WIPE;
                end
                CLR_WIPE: begin
                    clr_reg <= CLR_REQUEST;       // wiping happens in the fault process
                end
                CLR_REQUEST: begin
                    req_reg <= 1'b1;
                    clr_reg <= CLR_WAIT_NF;
                end
                CLR_WAIT_NF: begin
                    // no timeout: a drive that never reports leaves the command at one
                    if (drive_nonfault) begin
                        req_reg <= 1'b0;
                        clr_reg <= CLR_RESUME;
                    end
                end
                CLR_RESUME: begin
                    mon_reg <= 1'b1;
                    clr_reg <= CLR_IDLE;
                end
                default: begin
                    clr_reg <= CLR_IDLE;
                end
            endcase
        end
    end

    // fault latches and counter; non-clearable ones are out of reach of the wipe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            latch_reg   <= '0;
            fcount_reg  <= 32'h0000_0000;
            nclatch_reg <= '0;
        end else begin
            nclatch_reg <= nclatch_reg | nonclear_fault;
            if (wipe) begin
                latch_reg  <= '0;
                fcount_reg <= 32'h0000_0000;
            end else if (any_new) begin
                latch_reg  <= latch_reg | new_fault;
                fcount_reg <= fcount_reg + 32'h0000_0001;
            end
        end
    end

    // timestamp seconds counter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tick_reg  <= 32'h0000_0000;
            stamp_reg <= 32'h0000_0000;
        end else if (tick_reg == 32'(STAMP_CYCLES - 1)) begin
            tick_reg  <= 32'h0000_0000;
            stamp_reg <= stamp_reg + 32'h0000_0001;
        end else begin
            tick_reg  <= tick_reg + 32'h0000_0001;
        end
    end

    // history pointers: a new latch writes one entry, ring wraps over oldest
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wpos_reg  <= '0;
            steps_reg <= 32'h0000_0000;
            ridx_reg  <= 16'h0000;
        end else begin
            if (any_new) begin
                wpos_reg  <= ring_next(wpos_reg);
                steps_reg <= steps_reg + 32'h0000_0001;
            end
            if (wr_ridx) begin
                ridx_reg <= writedata[15:0];
            end
        end
    end

    // history storage, no reset so it acts as a memory array
    always_ff @(posedge clk) begin
        if (any_new) begin
            hist_mem[wpos_reg] <= '{stamp: stamp_reg,
                                    code:  first_set(new_fault),
                                    snap:  {8'h00, flags, fcount_reg[15:0]}};
        end
    end

    // interrupt status and mask; a new event beats a same-cycle clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sts_reg  <= '0;
            mask_reg <= MASK_RESET;
            irq_reg  <= 1'b0;
        end else begin
            sts_reg <= (sts_reg & ~(wr_sts ? writedata[EV_W-1:0] : '0)) | ev;
            if (wr_mask) begin
                mask_reg <= writedata[EV_W-1:0];
            end
            irq_reg <= |(sts_reg & mask_reg);
        end
    end

    // outputs straight from flip-flops
    assign readdata      = rdata_reg;
    assign waitrequest   = wait_reg;
    assign nonfault_req  = req_reg;
    assign fault_latched = latch_reg;
    assign monitor_on    = mon_reg;
    assign irq           = irq_reg;

endmodule
